// file: pswrc_top.sv
`timescale 1ns/100ps
// How it works
// - Two resets; cold also applies warm
// - Cold reset loads every reset value
// - Warm reset keeps debug control fields
// - Reset request bit causes delayed warm reset
// - Warm reset leaves halted debug state
// - Wait-for-event with latch clear sleeps
// - Wait-for-event with latch set completes
// - Event sleep ends on wakeup events
// - Pending exception wakes when enabled
// - Preempting exception wakes event sleep
// - Sleep keeps memory coherent
// - One event latch bit only
// - Latch set by events, entry, return
// - Reset clears the event latch
// - Latch invisible to software
// - Interrupt sleep wakes on its event set
// - Return to thread sleeps when enabled
// - Sleep point in return is ours
// - Return sleep uses interrupt wake set
module pswrc_top (
    input  wire logic                       mclk_i,
    input  wire logic                       srst_i,
    input  wire logic                       warm_rst_req_i,
    input  wire logic                       system_reset_request_i,
    input  wire logic                       scr_wr_i,
    input  wire logic [1:0]                 scr_wdata_i,
    input  wire logic                       dbg_ctrl_wr_i,
    input  wire logic [3:0]                 dbg_ctrl_wdata_i,
    input  wire logic                       debug_halted_i,
    input  wire logic                       wait_for_event_instr_i,
    input  wire logic                       wait_for_interrupt_instr_i,
    input  wire logic                       send_event_instr_i,
    input  wire logic                       peer_send_event_i,
    input  wire logic                       exc_entry_i,
    input  wire logic                       exception_return_value_i,
    input  wire logic                       exception_return_value_mode_i,
    input  wire logic                       pend_set_i,
    input  wire pswrc_pkg::pswrc_pend_t     pend_i,
    input  wire pswrc_pkg::pswrc_prio_ctx_t ctx_i,
    input  wire logic                       debug_en_i,
    input  wire logic                       debug_event_i,
    input  wire logic                       impl_wake_i,
    output logic                            sleeping_o,
    output logic                            instr_done_o,
    output logic                            warm_reset_o,
    output logic                            debug_exit_o,
    output logic                            send_event_on_pending_en_o,
    output logic                            sleep_on_return_en_o,
    output logic [3:0]                      dbg_ctrl_o
);

    localparam int SRQ_DLY = int'(pswrc_pkg::SYSRST_DLY_CYC) + 1;

    pswrc_pkg::pswrc_state_t state_q;
    pswrc_pkg::pswrc_state_t state_d;
    pswrc_pkg::pswrc_wake_t  wake;
    logic [4:0]              srq_cnt_q;
    logic                    warm_q;
    logic                    any_rst;
    logic [1:0]              scr_q;
    logic                    latch_q;
    logic                    latch_set;
    logic                    latch_clr;
    logic                    done_d;
    logic                    ret_sleep;

    // ------------------------------------------------------------
    // Reset generation
    // ------------------------------------------------------------
    // Cold reset always takes the warm path as well
    assign any_rst = srst_i || warm_q;

    // Request is held off for a settle time; repeats meanwhile fold
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            srq_cnt_q <= 5'h00;
        end else if (srq_cnt_q != 5'h00) begin
            srq_cnt_q <= srq_cnt_q - 5'h01;
        end else if (system_reset_request_i) begin
            srq_cnt_q <= pswrc_pkg::SYSRST_DLY_CNT;
        end
    end

    // One-cycle warm reset pulse
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            warm_q <= 1'b0;
        end else begin
            warm_q <= warm_rst_req_i || (srq_cnt_q == 5'h01);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            warm_reset_o <= 1'b0;
        end else begin
            warm_reset_o <= warm_q;
        end
    end

    // Warm reset pulls a halted core back out of debug
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            debug_exit_o <= 1'b0;
        end else begin
            debug_exit_o <= warm_q && debug_halted_i;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // System control bits take their reset value on either reset
    always_ff @(posedge mclk_i) begin
        if (any_rst) begin
            scr_q <= pswrc_pkg::SCR_RST;
        end else if (scr_wr_i) begin
            scr_q <= scr_wdata_i;
        end
    end

    // Debug control survives warm reset; only cold clears it
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dbg_ctrl_o <= pswrc_pkg::DBG_CTRL_RST;
        end else if (dbg_ctrl_wr_i) begin
            dbg_ctrl_o <= dbg_ctrl_wdata_i;
        end
    end

    assign send_event_on_pending_en_o = scr_q[pswrc_pkg::SCR_SEVPEND_BIT];
    assign sleep_on_return_en_o       = scr_q[pswrc_pkg::SCR_SLEEPRET_BIT];

    // ------------------------------------------------------------
    // Wakeup evaluation and event latch
    // ------------------------------------------------------------
    pswrc_wake_eval u_wake (
        .ctx_i        (ctx_i),
        .pend_i       (pend_i),
        .sev_any_i    (send_event_instr_i || peer_send_event_i),
        .pend_evt_i   (pend_set_i),
        .sevpend_en_i (scr_q[pswrc_pkg::SCR_SEVPEND_BIT]),
        .dbg_en_i     (debug_en_i),
        .dbg_evt_i    (debug_event_i),
        .impl_evt_i   (impl_wake_i),
        .wake_o       (wake)
    );

    // Only hardware events and the wait instruction touch the bit
    assign latch_set = wake.wfe_wake || exc_entry_i || exception_return_value_i;
    assign latch_clr = (state_q == pswrc_pkg::ST_RUN &&
                        wait_for_event_instr_i && latch_q) ||
                       (state_q == pswrc_pkg::ST_WFE);

    pswrc_event_latch u_latch (
        .mclk_i  (mclk_i),
        .rst_i   (any_rst),
        .set_i   (latch_set),
        .clr_i   (latch_clr),
        .latch_o (latch_q)
    );

    // ------------------------------------------------------------
    // Sleep state machine
    // ------------------------------------------------------------
    // Sleep is only a hint: clocks and the memory path keep running,
    // so no outstanding access is dropped while asleep
    assign ret_sleep = exception_return_value_i && exception_return_value_mode_i &&
                       scr_q[pswrc_pkg::SCR_SLEEPRET_BIT];

    always_comb begin
        state_d = state_q;
        done_d  = 1'b0;
        unique case (state_q)
            pswrc_pkg::ST_RUN: begin
                if (wait_for_event_instr_i) begin
                    if (latch_q) begin
                        done_d = 1'b1;
                    end else begin
                        state_d = pswrc_pkg::ST_WFE;
                    end
                end else if (wait_for_interrupt_instr_i) begin
                    state_d = pswrc_pkg::ST_WFI;
                end else if (ret_sleep) begin
                    // Sleep taken at the end of the return sequence
                    state_d = pswrc_pkg::ST_EXIT;
                end
            end
            pswrc_pkg::ST_WFE: begin
                // An event caught while entering shows in the latch
                if (wake.wfe_wake || latch_q) begin
                    state_d = pswrc_pkg::ST_RUN;
                    done_d  = 1'b1;
                end
            end
            pswrc_pkg::ST_WFI, pswrc_pkg::ST_EXIT: begin
                if (wake.wfi_wake) begin
                    state_d = pswrc_pkg::ST_RUN;
                    done_d  = 1'b1;
                end
            end
        endcase
    end

    // Any reset wakes straight into run
    always_ff @(posedge mclk_i) begin
        if (any_rst) begin
            state_q <= pswrc_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Flag follows the next state so it drops on the wake edge
    always_ff @(posedge mclk_i) begin
        if (any_rst) begin
            sleeping_o   <= 1'b0;
            instr_done_o <= 1'b0;
        end else begin
            sleeping_o   <= state_d != pswrc_pkg::ST_RUN;
            instr_done_o <= done_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sleep_flag_a: assert property (
        @(posedge mclk_i) disable iff (any_rst)
        sleeping_o == (state_q != pswrc_pkg::ST_RUN))
        else $error("sleeping flag disagrees with state");

    wfe_set_done_a: assert property (
        @(posedge mclk_i) disable iff (any_rst)
        (state_q == pswrc_pkg::ST_RUN && wait_for_event_instr_i &&
         latch_q) |=> (instr_done_o && !sleeping_o))
        else $error("set latch did not complete wait at once");

    wfe_sleep_a: assert property (
        @(posedge mclk_i) disable iff (any_rst)
        (state_q == pswrc_pkg::ST_RUN && wait_for_event_instr_i &&
         !latch_q) |=> sleeping_o)
        else $error("wait for event did not sleep");

    wfe_wake_a: assert property (
        @(posedge mclk_i) disable iff (any_rst)
        (state_q == pswrc_pkg::ST_WFE && wake.wfe_wake)
        |=> (instr_done_o && !sleeping_o))
        else $error("event sleep missed its wakeup");

    wfi_wake_a: assert property (
        @(posedge mclk_i) disable iff (any_rst)
        (state_q inside {pswrc_pkg::ST_WFI, pswrc_pkg::ST_EXIT} &&
         wake.wfi_wake) |=> (instr_done_o && !sleeping_o))
        else $error("interrupt sleep missed its wakeup");

    ret_sleep_a: assert property (
        @(posedge mclk_i) disable iff (any_rst)
        (state_q == pswrc_pkg::ST_RUN && !wait_for_event_instr_i &&
         !wait_for_interrupt_instr_i && ret_sleep)
        |=> (state_q == pswrc_pkg::ST_EXIT))
        else $error("return to thread did not sleep");

    srq_delay_a: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        (system_reset_request_i && srq_cnt_q == 5'h00)
        |-> ##SRQ_DLY warm_q)
        else $error("reset request did not give warm reset");

    dbg_keep_a: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        (warm_q && !dbg_ctrl_wr_i) |=> $stable(dbg_ctrl_o))
        else $error("warm reset changed debug control");

    dbg_exit_a: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        (warm_q && debug_halted_i) |=> debug_exit_o)
        else $error("warm reset left core halted");

    wfi_sleep_a: assert property (
        @(posedge mclk_i) disable iff (any_rst)
        (state_q == pswrc_pkg::ST_RUN && !wait_for_event_instr_i &&
         wait_for_interrupt_instr_i) |=> sleeping_o)
        else $error("wait for interrupt did not sleep");

    wfe_wait_a: assert property (
        @(posedge mclk_i) disable iff (any_rst)
        (state_q == pswrc_pkg::ST_WFE && !wake.wfe_wake && !latch_q)
        |=> (sleeping_o && !instr_done_o))
        else $error("event sleep ended without a wakeup");

    warm_clear_a: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        warm_q |=> (!sleeping_o && !instr_done_o &&
                    scr_q == pswrc_pkg::SCR_RST))
        else $error("warm reset left sleep state behind");

    cold_dbg_a: assert property (
        @(posedge mclk_i)
        srst_i |=> (dbg_ctrl_o == pswrc_pkg::DBG_CTRL_RST))
        else $error("cold reset kept debug control");

    warm_out_a: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        warm_q |=> warm_reset_o)
        else $error("warm reset not shown on its output");

endmodule // pswrc_top

// file: pswrc_pkg.sv
package pswrc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    // Settle time between a system reset request and the warm reset
    localparam int unsigned SYSRST_DLY_NS = 200;
    localparam int unsigned SYSRST_DLY_CYC =
        (SYSRST_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] SYSRST_DLY_CNT = 5'(SYSRST_DLY_CYC);

    // ------------------------------------------------------------
    // Priorities, fields and reset values
    // ------------------------------------------------------------
    localparam logic [8:0] PRIO_THREAD     = 9'h100;
    localparam logic [8:0] PRIO_TOP        = 9'h000;
    localparam int unsigned SCR_SEVPEND_BIT = 0;
    localparam int unsigned SCR_SLEEPRET_BIT = 1;
    localparam logic [1:0] SCR_RST         = 2'h0;
    localparam logic [3:0] DBG_CTRL_RST    = 4'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [8:0] active_prio;  // Priority of active exceptions
        logic [7:0] base_pri;     // Base priority mask, 0 is off
        logic       excp_mask;    // Single-bit exception mask
        logic       fault_mask;   // Fault mask
        logic       prio_split;   // Priority split select
    } pswrc_prio_ctx_t;

    typedef struct packed {
        logic [7:0] prio;         // Highest pending priority
        logic       nonsec;       // Pending one is non-secure
        logic       async;        // Pending one is asynchronous
        logic       valid;        // Something is pending
    } pswrc_pend_t;

    typedef struct packed {
        logic wfe_wake;
        logic wfi_wake;
    } pswrc_wake_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_WFE,
        ST_WFI,
        ST_EXIT
    } pswrc_state_t;

endpackage

// file: pswrc_event_latch.sv
`timescale 1ns/100ps
module pswrc_event_latch (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      latch_o
);

    // ------------------------------------------------------------
    // Single event bit, no software path to it
    // ------------------------------------------------------------
    // Set wins over clear so a racing event is never lost
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            latch_o <= 1'b0;
        end else if (set_i) begin
            latch_o <= 1'b1;
        end else if (clr_i) begin
            latch_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    latch_set_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        set_i |=> latch_o)
        else $error("event latch missed a set");

    latch_reset_a: assert property (
        @(posedge mclk_i) rst_i |=> !latch_o)
        else $error("event latch survived reset");

endmodule // pswrc_event_latch

// file: pswrc_wake_eval.sv
`timescale 1ns/100ps
module pswrc_wake_eval (
    input  wire pswrc_pkg::pswrc_prio_ctx_t ctx_i,
    input  wire pswrc_pkg::pswrc_pend_t     pend_i,
    input  wire logic                       sev_any_i,
    input  wire logic                       pend_evt_i,
    input  wire logic                       sevpend_en_i,
    input  wire logic                       dbg_en_i,
    input  wire logic                       dbg_evt_i,
    input  wire logic                       impl_evt_i,
    output pswrc_pkg::pswrc_wake_t          wake_o
);

    // ------------------------------------------------------------
    // Priority helpers, lower number is more urgent
    // ------------------------------------------------------------
    // Split setting pushes non-secure priorities into the upper half, 0x80 and above
    function automatic logic [8:0] eff_prio(
        input pswrc_pkg::pswrc_pend_t     p,
        input pswrc_pkg::pswrc_prio_ctx_t c);
        if (c.prio_split && p.nonsec) begin
            eff_prio = {1'b0, 1'b1, p.prio[7:1]};
        end else begin
            eff_prio = {1'b0, p.prio};
        end
    endfunction

    // Execution priority, masks boost it; base mask of zero is off
    function automatic logic [8:0] exec_prio(
        input pswrc_pkg::pswrc_prio_ctx_t c,
        input logic                       use_pm);
        logic [8:0] e;
        e = c.active_prio;
        if (c.base_pri != 8'h00 && {1'b0, c.base_pri} < e) begin
            e = {1'b0, c.base_pri};
        end
        if ((use_pm && c.excp_mask) || c.fault_mask) begin
            e = pswrc_pkg::PRIO_TOP;
        end
        exec_prio = e;
    endfunction

    logic preempt_all;
    logic preempt_nopm;
    logic dbg_wake;

    // ------------------------------------------------------------
    // Wakeup sets
    // ------------------------------------------------------------
    always_comb begin
        preempt_all  = pend_i.valid &&
            (eff_prio(pend_i, ctx_i) < exec_prio(ctx_i, 1'b1));
        preempt_nopm = pend_i.valid && pend_i.async &&
            (eff_prio(pend_i, ctx_i) < exec_prio(ctx_i, 1'b0));
        dbg_wake     = dbg_en_i && dbg_evt_i;
        wake_o.wfe_wake = sev_any_i || preempt_all || dbg_wake ||
            (sevpend_en_i && pend_evt_i);
        wake_o.wfi_wake = preempt_nopm || impl_evt_i || dbg_wake;
    end

endmodule // pswrc_wake_eval

// file: pswrc_peer_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Peer element answering with a send-event
// ------------------------------------------------------------
module pswrc_peer_model (
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic       go_i,
    input  wire logic [3:0] dly_i,
    output logic            sev_o
);
    logic [4:0] cnt_q;

    // Countdown, zero is idle; a long delay mimics a slow peer
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cnt_q <= 5'h00;
            sev_o <= 1'b0;
        end else begin
            sev_o <= (cnt_q == 5'h01);
            if (go_i) begin
                cnt_q <= {1'b0, dly_i} + 5'h01;
            end else if (cnt_q != 5'h00) begin
                cnt_q <= cnt_q - 5'h01;
            end
        end
    end
endmodule // pswrc_peer_model

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
    logic mclk_i, srst_i, wrq, srq, scr_wr, dbg_wr, halt, wait_for_event_instr, wait_for_interrupt_instr, send_event_instr;
    logic ent, ret, mode, pset, den, devt, impl, go, peer_sev;
    logic [1:0] scr_wd;
    logic [3:0] dbg_wd, dly, dbg_ctrl;
    logic slp, done, warm, dexit, sp_en, sr_en;
    pswrc_pkg::pswrc_pend_t     pend;
    pswrc_pkg::pswrc_prio_ctx_t ctx;
    logic [15:0] rnd;
    int mismatches, comparisons, n, k;
    logic seen, exp;

    pswrc_top uut (.mclk_i(mclk_i), .srst_i(srst_i), .warm_rst_req_i(wrq),
        .system_reset_request_i(srq), .scr_wr_i(scr_wr), .scr_wdata_i(scr_wd),
        .dbg_ctrl_wr_i(dbg_wr), .dbg_ctrl_wdata_i(dbg_wd),
        .debug_halted_i(halt), .wait_for_event_instr_i(wait_for_event_instr),
        .wait_for_interrupt_instr_i(wait_for_interrupt_instr), .send_event_instr_i(send_event_instr),
        .peer_send_event_i(peer_sev), .exc_entry_i(ent), .exception_return_value_i(ret),
        .exception_return_value_mode_i(mode), .pend_set_i(pset), .pend_i(pend),
        .ctx_i(ctx), .debug_en_i(den), .debug_event_i(devt),
        .impl_wake_i(impl), .sleeping_o(slp), .instr_done_o(done),
        .warm_reset_o(warm), .debug_exit_o(dexit),
        .send_event_on_pending_en_o(sp_en), .sleep_on_return_en_o(sr_en),
        .dbg_ctrl_o(dbg_ctrl));

    pswrc_peer_model peer (.mclk_i(mclk_i), .srst_i(srst_i), .go_i(go),
        .dly_i(dly), .sev_o(peer_sev));

    // ------------------------------------------------------------
    // Clock, helpers
    // ------------------------------------------------------------
    always #5 mclk_i = ~mclk_i;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Event wake by priority; strict compare, masks force level 0
    function automatic logic exp_wake(pswrc_pkg::pswrc_prio_ctx_t c,
                                      pswrc_pkg::pswrc_pend_t p);
        logic [8:0] ep;
        logic [8:0] pp;
        // Split moves non-secure priorities to 0x80 plus half
        pp = (c.prio_split && p.nonsec) ? {2'b01, p.prio[7:1]}
                                        : {1'b0, p.prio};
        ep = c.active_prio;
        if (c.base_pri != 8'h00 && {1'b0, c.base_pri} < ep) begin
            ep = {1'b0, c.base_pri};
        end
        if (c.excp_mask || c.fault_mask) begin
            ep = 9'h000;
        end
        return p.valid && (pp < ep);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        comparisons++;
        if (got !== want) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    // One-cycle pulse launched at a falling edge
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge mclk_i);
        s = 1'b0;
    endtask

    // Wait loop as software would write it: retry until asleep
    task automatic wfe_sleep;
        repeat (3) if (slp !== 1'b1) begin
            pulse(wait_for_event_instr);
            @(negedge mclk_i);
        end
        chk(slp, 1'b1);
    endtask

    task automatic wake_wait;
        for (int i = 0; i < 30 && slp === 1'b1; i++) @(negedge mclk_i);
        chk({slp, done}, 2'b01);
    endtask

    task automatic complete_run;
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog sized far above the few hundred cycles used
    initial begin
        #200000;
        mismatches++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {mclk_i, wrq, srq, scr_wr, dbg_wr, halt, wait_for_event_instr, wait_for_interrupt_instr, send_event_instr} = '0;
        {ent, ret, mode, pset, den, devt, impl, go, scr_wd} = '0;
        {dbg_wd, dly, pend, ctx} = '0;
        ctx.active_prio = pswrc_pkg::PRIO_THREAD;
        rnd = 16'h1c10;
        mismatches = 0;
        comparisons = 0;
        srst_i = 1'b1;
        repeat (8) @(negedge mclk_i);
        srst_i = 1'b0;
        @(negedge mclk_i);
        chk({slp, done, warm, dexit, sp_en, sr_en, dbg_ctrl}, 16'h0000);
        // Sleep with latch clear, local send-event wakes exactly
        pulse(wait_for_event_instr);
        chk(slp, 1'b1);
        @(negedge mclk_i);
        pulse(send_event_instr);
        chk({slp, done}, 2'b01);
        @(negedge mclk_i);
        chk(done, 1'b0);
        // Latch setters: peer send-event, entry, return
        for (k = 0; k < 3; k++) begin
            @(negedge mclk_i);
            case (k)
                0: pulse(go);
                1: pulse(ent);
                default: pulse(ret);
            endcase
            repeat (3) @(negedge mclk_i);
            pulse(wait_for_event_instr);
            chk({slp, done}, 2'b01);
            @(negedge mclk_i);
            pulse(wait_for_event_instr);
            chk(slp, 1'b1);
            dly = (k == 1) ? 4'h6 : 4'h0;
            @(negedge mclk_i);
            pulse(go);
            wake_wait();
            @(negedge mclk_i);
            pulse(wait_for_event_instr);
            chk(done, 1'b1);
        end
        // Random priority wakes, strict boundary first
        for (k = 0; k < 10; k++) begin
            wfe_sleep();
            rnd = lfsr(rnd);
            ctx.active_prio = {1'b0, rnd[15:8]};
            if (rnd[0] || k < 2) ctx.active_prio = pswrc_pkg::PRIO_THREAD;
            ctx.base_pri = (k == 1) ? 8'h40 : rnd[11:4];
            if (k == 0) ctx.base_pri = 8'h00;
            ctx.excp_mask = (k >= 2) && rnd[2] && rnd[3];
            ctx.fault_mask = (k >= 2) && rnd[1] && rnd[5];
            ctx.prio_split = (k >= 2) && rnd[6];
            pend.nonsec = rnd[9];
            pend.prio = (k == 0) ? 8'hff : (k == 1) ? 8'h40 : rnd[7:0];
            pend.valid = 1'b1;
            exp = exp_wake(ctx, pend);
            repeat (2) @(negedge mclk_i);
            chk(slp, !exp);
            pend.valid = 1'b0;
            if (slp === 1'b1) begin
                pulse(send_event_instr);
                wake_wait();
            end
        end
        {ctx.excp_mask, ctx.fault_mask, ctx.base_pri} = '0;
        ctx.prio_split = 1'b0;
        pend.nonsec = 1'b0;
        ctx.active_prio = pswrc_pkg::PRIO_THREAD;
        // Pending-set wake, enabled then disabled
        for (k = 1; k >= 0; k--) begin
            scr_wd = k[1:0];
            pulse(scr_wr);
            chk(sp_en, k[0]);
            wfe_sleep();
            pulse(pset);
            chk({slp, done}, {!k[0], k[0]});
            @(negedge mclk_i);
            chk(slp, !k[0]);
            if (slp === 1'b1) begin
                pulse(send_event_instr);
                wake_wait();
            end
        end
        // Interrupt sleep ignores send-event and disabled debug
        for (k = 0; k < 3; k++) begin
            pulse(wait_for_interrupt_instr);
            pulse(send_event_instr);
            pulse(devt);
            repeat (2) @(negedge mclk_i);
            chk(slp, 1'b1);
            den = 1'b1;
            ctx.excp_mask = 1'b1;
            case (k)
                0: pulse(impl);
                1: pulse(devt);
                default: pend = '{8'h20, 1'b0, 1'b1, 1'b1};
            endcase
            wake_wait();
            {den, ctx.excp_mask, pend.valid} = '0;
        end
        // Sleep on return only when returning to thread
        scr_wd = 2'h2;
        pulse(scr_wr);
        chk(sr_en, 1'b1);
        pulse(ret);
        repeat (2) @(negedge mclk_i);
        chk(slp, 1'b0);
        mode = 1'b1;
        pulse(ret);
        mode = 1'b0;
        @(negedge mclk_i);
        chk(slp, 1'b1);
        pulse(send_event_instr);
        repeat (2) @(negedge mclk_i);
        chk(slp, 1'b1);
        pulse(impl);
        wake_wait();
        // Delayed warm reset, second request ignored
        dbg_wd = 4'ha;
        pulse(dbg_wr);
        pulse(send_event_instr);
        halt = 1'b1;
        seen = 1'b0;
        pulse(srq);
        for (n = 0; n < 60 && warm !== 1'b1; n++) begin
            if (n == 5) srq = 1'b1;
            if (n == 6) srq = 1'b0;
            seen |= (dexit === 1'b1);
            @(negedge mclk_i);
        end
        chk(n[15:0], 16'(pswrc_pkg::SYSRST_DLY_CYC + 1));
        repeat (2) begin
            seen |= (dexit === 1'b1);
            @(negedge mclk_i);
        end
        chk(seen, 1'b1);
        chk({dbg_ctrl, sp_en, sr_en}, 16'h0028);
        halt = 1'b0;
        pulse(wait_for_event_instr);
        chk(slp, 1'b1);
        // External warm request clears sleep, cold clears debug
        pulse(wrq);
        @(negedge mclk_i);
        chk({warm, slp}, 2'b10);
        srst_i = 1'b1;
        @(negedge mclk_i);
        srst_i = 1'b0;
        chk(dbg_ctrl, 4'h0);
        complete_run();
    end
endmodule // testbench
